//--- design/nvm_pkg.sv
// Shared constants, types and decode helpers for the flash/EEPROM
// command sequencer block.
// Assumes a single 40 MHz bus clock and word-aligned APB offsets.
package nvm_pkg;

  localparam int CLK_PERIOD_NS = 25;
  // Length of one program or erase algorithm
  localparam int ALG_TIME_NS   = 2000;
  localparam int ALG_CYCLES    =
    (ALG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] ALG_CNT_MAX = 7'(ALG_CYCLES - 1);
  localparam logic [6:0] CNT_ZERO    = 7'h00;

  localparam logic [7:0] FLASH_CMD_OFS  = 8'h00;
  localparam logic [7:0] FLASH_STAT_OFS = 8'h04;
  localparam logic [7:0] EE_CMD_OFS     = 8'h08;
  localparam logic [7:0] EE_STAT_OFS    = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS    = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS     = 8'h18;
  localparam logic [7:0] CTRL_OFS       = 8'h1C;

  localparam int STAT_CBE_BIT  = 7;
  localparam int STAT_CC_BIT   = 6;
  localparam int STAT_FAIL_BIT = 4;
  localparam int STAT_HUNG_BIT = 0;

  localparam int CTRL_SPECIAL_BIT = 0;
  localparam int CTRL_BLK_LSB     = 1;
  localparam int CTRL_BLK_MSB     = 2;
  localparam logic [1:0] FLASH_BLK0 = 2'h0;

  localparam int IRQ_FDONE_BIT = 0;
  localparam int IRQ_EDONE_BIT = 1;
  localparam int IRQ_FHUNG_BIT = 2;
  localparam int IRQ_EHUNG_BIT = 3;

  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROGRAM      = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;

  localparam logic [7:0]  CMD_RST    = 8'h00;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [3:0]  IRQ_RST    = 4'h0;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_BUSY = 2'b01,
    SEQ_HUNG = 2'b10
  } seq_state_e;

  function automatic logic cmd_legal(input logic [7:0] c);
    return (c == CMD_ERASE_VERIFY) || (c == CMD_PROGRAM) ||
           (c == CMD_SECTOR_ERASE) || (c == CMD_MASS_ERASE);
  endfunction

endpackage

//--- design/nvm_command_status_flags.sv
// Flash and EEPROM command sequencers with their status flags, an
// APB register file and a level interrupt.
// Assumes cpu_stop comes from the CPU on the same pclk domain.
//
// Behaviour
// R1: STOP during running algorithm aborts it immediately
// R2: Abort leaves command-complete flag clear
// R3: Abort with queued command keeps buffer-empty clear
// R4: After abort, sequencer hangs, rejects commands until reset
// R5: EEPROM sequencer aborts and hangs the same way
// R6: Illegal flash block 0 command, special mode: no fail
// R7: Illegal EEPROM command in special mode: no fail
// R8: Software must not STOP during running algorithm
// R9: Differing command written while queued cancels pending
// R10: Buffer-empty when loadable; complete when idle, nothing queued

module nvm_seq (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cpu_stop,
  input  wire logic       fail_set_en,
  input  wire logic       fail_clr,
  output logic            buf_empty,
  output logic            cmd_done,
  output logic            fail,
  output logic            hung,
  output logic            busy,
  output logic            done_pulse,
  output logic            abort_pulse,
  output logic [7:0]      last_cmd
);

  nvm_pkg::seq_state_e state_ff, nxt_state;
  logic [6:0] cnt_ff,    nxt_cnt;
  logic [7:0] pend_ff,   nxt_pend;
  logic       pend_v_ff, nxt_pend_v;
  logic       fail_ff,   nxt_fail;
  logic       done_ff,   nxt_done;
  logic       abort_ff,  nxt_abort;
  logic [7:0] last_ff,   nxt_last;
  logic       launch;
  logic       aborting;

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_pend   = pend_ff;
    nxt_pend_v = pend_v_ff;
    nxt_fail   = fail_ff;
    nxt_done   = 1'b0;
    nxt_abort  = 1'b0;
    nxt_last   = last_ff;
    launch     = 1'b0;
    aborting   = 1'b0;
    if (fail_clr) begin
      nxt_fail = 1'b0;
    end
    unique case (state_ff)
      nvm_pkg::SEQ_IDLE: begin
        if (pend_v_ff) begin
          launch = 1'b1;
        end
      end
      nvm_pkg::SEQ_BUSY: begin
        if (cpu_stop) begin
          // Pending stays queued, so buffer-empty never rises
          aborting  = 1'b1;
          nxt_state = nvm_pkg::SEQ_HUNG; // [R1] [R2] [R3] [R5]
          nxt_abort = 1'b1;
        end else if (cnt_ff == nvm_pkg::CNT_ZERO) begin
          nxt_done = 1'b1;
          if (pend_v_ff) begin
            launch = 1'b1;
          end else begin
            nxt_state = nvm_pkg::SEQ_IDLE;
          end
        end else begin
          nxt_cnt = cnt_ff - 7'h01;
        end
      end
      nvm_pkg::SEQ_HUNG: begin
        // Only reset leaves this state
        nxt_state = nvm_pkg::SEQ_HUNG; // [R4]
      end
      default: begin
        nxt_state = nvm_pkg::SEQ_IDLE;
      end
    endcase
    if (launch) begin
      nxt_state  = nvm_pkg::SEQ_BUSY;
      nxt_cnt    = nvm_pkg::ALG_CNT_MAX;
      nxt_pend_v = 1'b0;
    end
    // A hung or aborting sequencer ignores every command write
    if (cmd_wr && (state_ff != nvm_pkg::SEQ_HUNG) && !aborting) begin // [R4]
      if (!nvm_pkg::cmd_legal(cmd_data)) begin
        if (fail_set_en) begin
          nxt_fail = 1'b1; // [R6] [R7]
        end
      end else if (!pend_v_ff || launch) begin
        nxt_pend   = cmd_data;
        nxt_pend_v = 1'b1;
        nxt_last   = cmd_data;
      end else if (cmd_data != pend_ff) begin
        nxt_pend_v = 1'b0; // [R9]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= nvm_pkg::SEQ_IDLE;
      cnt_ff    <= nvm_pkg::CNT_ZERO;
      pend_ff   <= nvm_pkg::CMD_RST;
      pend_v_ff <= 1'b0;
      fail_ff   <= 1'b0;
      done_ff   <= 1'b0;
      abort_ff  <= 1'b0;
      last_ff   <= nvm_pkg::CMD_RST;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pend_ff   <= nxt_pend;
      pend_v_ff <= nxt_pend_v;
      fail_ff   <= nxt_fail;
      done_ff   <= nxt_done;
      abort_ff  <= nxt_abort;
      last_ff   <= nxt_last;
    end
  end

  assign buf_empty   = !pend_v_ff; // [R10]
  assign cmd_done    = (state_ff == nvm_pkg::SEQ_IDLE) && !pend_v_ff; // [R10]
  assign fail        = fail_ff;
  assign hung        = (state_ff == nvm_pkg::SEQ_HUNG);
  assign busy        = (state_ff == nvm_pkg::SEQ_BUSY);
  assign done_pulse  = done_ff;
  assign abort_pulse = abort_ff;
  assign last_cmd    = last_ff;

  sequence s_abort;
    busy && cpu_stop;
  endsequence

  sequence s_hung_quiet;
    hung && !busy && !cmd_done;
  endsequence

  a_stop_aborts: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    s_abort |=> s_hung_quiet ##0 abort_pulse)
    else $error("STOP did not abort the running algorithm");

  a_complete_stays_clear: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    s_abort |=> (!cmd_done && !done_pulse) [*4])
    else $error("Complete flag set after abort");

  a_queued_empty_clear: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    (s_abort ##0 !buf_empty) |=> !buf_empty [*4])
    else $error("Buffer-empty set after abort with queued command");

  a_hung_rejects_cmds: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    hung |=> s_hung_quiet ##0 $stable(buf_empty) ##0 $stable(last_cmd))
    else $error("Hung sequencer accepted a command or recovered");

  a_differ_cancels: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    (cmd_wr && pend_v_ff && busy && !cpu_stop && (cnt_ff != 7'h00) &&
     nvm_pkg::cmd_legal(cmd_data) && (cmd_data != pend_ff))
    |=> buf_empty)
    else $error("Differing command did not cancel the pending one");

  a_done_needs_empty: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    cmd_done |-> buf_empty && !busy && !hung)
    else $error("Complete flag with command active or queued");

endmodule

module nvm_command_status_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        cpu_stop,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [2:0]  ctrl_ff,   nxt_ctrl;
  logic [3:0]  irq_en_ff, nxt_irq_en;
  logic [3:0]  irq_sts_ff, nxt_irq_sts;
  logic        irq_ff,    nxt_irq;

  logic        wr_acc;
  logic        f_wr, e_wr;
  logic        f_fail_clr, e_fail_clr;
  logic        special;
  logic [1:0]  flash_blk;
  logic        f_be, f_cc, f_fail, f_hung, f_busy, f_done, f_abort;
  logic        e_be, e_cc, e_fail, e_hung, e_busy, e_done, e_abort;
  logic [7:0]  f_last, e_last;
  logic [3:0]  events;

  function automatic logic [31:0] stat_word(input logic be,
                                            input logic cc,
                                            input logic fl,
                                            input logic hg);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[nvm_pkg::STAT_CBE_BIT]  = be;
    w[nvm_pkg::STAT_CC_BIT]   = cc;
    w[nvm_pkg::STAT_FAIL_BIT] = fl;
    w[nvm_pkg::STAT_HUNG_BIT] = hg;
    return w;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == nvm_pkg::FLASH_CMD_OFS) || (a == nvm_pkg::FLASH_STAT_OFS) ||
           (a == nvm_pkg::EE_CMD_OFS)    || (a == nvm_pkg::EE_STAT_OFS)    ||
           (a == nvm_pkg::IRQ_STAT_OFS)  || (a == nvm_pkg::IRQ_CLR_OFS)    ||
           (a == nvm_pkg::IRQ_EN_OFS)    || (a == nvm_pkg::CTRL_OFS);
  endfunction

  // Writes land in the access cycle, the only one with pready high
  assign wr_acc     = psel && penable && pready_ff && pwrite &&
                      mapped(paddr);
  assign f_wr       = wr_acc && (paddr == nvm_pkg::FLASH_CMD_OFS);
  assign e_wr       = wr_acc && (paddr == nvm_pkg::EE_CMD_OFS);
  assign f_fail_clr = wr_acc && (paddr == nvm_pkg::FLASH_STAT_OFS) &&
                      pwdata[nvm_pkg::STAT_FAIL_BIT];
  assign e_fail_clr = wr_acc && (paddr == nvm_pkg::EE_STAT_OFS) &&
                      pwdata[nvm_pkg::STAT_FAIL_BIT];
  assign special    = ctrl_ff[nvm_pkg::CTRL_SPECIAL_BIT];
  assign flash_blk  = ctrl_ff[nvm_pkg::CTRL_BLK_MSB:nvm_pkg::CTRL_BLK_LSB];

  nvm_seq u_flash (
    .pclk        (pclk),
    .presetn     (presetn),
    .cmd_wr      (f_wr),
    .cmd_data    (pwdata[7:0]),
    .cpu_stop    (cpu_stop),
    .fail_set_en (!(special && (flash_blk == nvm_pkg::FLASH_BLK0))), // [R6]
    .fail_clr    (f_fail_clr),
    .buf_empty   (f_be),
    .cmd_done    (f_cc),
    .fail        (f_fail),
    .hung        (f_hung),
    .busy        (f_busy),
    .done_pulse  (f_done),
    .abort_pulse (f_abort),
    .last_cmd    (f_last)
  );

  nvm_seq u_eeprom (
    .pclk        (pclk),
    .presetn     (presetn),
    .cmd_wr      (e_wr),
    .cmd_data    (pwdata[7:0]),
    .cpu_stop    (cpu_stop),
    .fail_set_en (!special), // [R7]
    .fail_clr    (e_fail_clr),
    .buf_empty   (e_be),
    .cmd_done    (e_cc),
    .fail        (e_fail),
    .hung        (e_hung),
    .busy        (e_busy),
    .done_pulse  (e_done),
    .abort_pulse (e_abort),
    .last_cmd    (e_last)
  );

  always_comb begin
    events                         = 4'h0;
    events[nvm_pkg::IRQ_FDONE_BIT] = f_done;
    events[nvm_pkg::IRQ_EDONE_BIT] = e_done;
    events[nvm_pkg::IRQ_FHUNG_BIT] = f_abort;
    events[nvm_pkg::IRQ_EHUNG_BIT] = e_abort;
    nxt_ctrl    = ctrl_ff;
    nxt_irq_en  = irq_en_ff;
    nxt_irq_sts = irq_sts_ff;
    if (wr_acc && (paddr == nvm_pkg::CTRL_OFS)) begin
      nxt_ctrl = pwdata[2:0];
    end
    if (wr_acc && (paddr == nvm_pkg::IRQ_EN_OFS)) begin
      nxt_irq_en = pwdata[3:0];
    end
    if (wr_acc && (paddr == nvm_pkg::IRQ_CLR_OFS)) begin
      nxt_irq_sts = irq_sts_ff & ~pwdata[3:0];
    end
    // Set after clear, so an event in the clearing cycle survives
    nxt_irq_sts = nxt_irq_sts | events;
    nxt_irq     = |(nxt_irq_sts & nxt_irq_en);
  end

  always_comb begin
    nxt_pready  = psel && !penable;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    // Read data is captured in setup, so the access answers at once
    if (psel && !penable) begin
      nxt_pslverr = !mapped(paddr);
      nxt_prdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          nvm_pkg::FLASH_CMD_OFS:  nxt_prdata = {24'h00_0000, f_last};
          nvm_pkg::FLASH_STAT_OFS: nxt_prdata =
            stat_word(f_be, f_cc, f_fail, f_hung);
          nvm_pkg::EE_CMD_OFS:     nxt_prdata = {24'h00_0000, e_last};
          nvm_pkg::EE_STAT_OFS:    nxt_prdata =
            stat_word(e_be, e_cc, e_fail, e_hung);
          nvm_pkg::IRQ_STAT_OFS:   nxt_prdata = {28'h000_0000, irq_sts_ff};
          nvm_pkg::IRQ_EN_OFS:     nxt_prdata = {28'h000_0000, irq_en_ff};
          nvm_pkg::CTRL_OFS:       nxt_prdata = {29'h000_0000, ctrl_ff};
          default:                 nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= nvm_pkg::PRDATA_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      ctrl_ff    <= nvm_pkg::CTRL_RST;
      irq_en_ff  <= nvm_pkg::IRQ_RST;
      irq_sts_ff <= nvm_pkg::IRQ_RST;
      irq_ff     <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      ctrl_ff    <= nxt_ctrl;
      irq_en_ff  <= nxt_irq_en;
      irq_sts_ff <= nxt_irq_sts;
      irq_ff     <= nxt_irq;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

  a_eeprom_abort_hang: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    (e_busy && cpu_stop) |=> (e_hung && !e_cc && !e_busy) [*3])
    else $error("EEPROM did not abort and hang on STOP");

  a_flash0_no_fail: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    (f_wr && !nvm_pkg::cmd_legal(pwdata[7:0]) && special &&
     (flash_blk == nvm_pkg::FLASH_BLK0) && !f_fail) |=> !f_fail)
    else $error("Flash block 0 fail set in special mode");

  a_eeprom_no_fail: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    (e_wr && !nvm_pkg::cmd_legal(pwdata[7:0]) && special && !e_fail)
    |=> !e_fail)
    else $error("EEPROM fail set in special mode");

endmodule

//--- testbench/nvm_command_status_flags_test.sv
// Self-checking bench for the flash/EEPROM command sequencer block.
// Assumes the zero-wait APB slave and the algorithm length of nvm_pkg.
module nvm_command_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic        cpu_stop    = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fails       = 0;
  int          check_count = 0;

  always #12.5 pclk = ~pclk;

  nvm_command_status_flags dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .cpu_stop(cpu_stop), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; an edge always passes before a new setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic wait_irq(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, nvm_pkg::IRQ_STAT_OFS, 32'h0000_0000);
      n++;
    end while (rd[b] !== 1'b1 && n < 60);
    if (rd[b] !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask

  // Longer than one algorithm, so a stray launch would finish in it
  task automatic idle();
    repeat (nvm_pkg::ALG_CYCLES + 10) @(posedge pclk);
  endtask

  task automatic stop_pulse();
    @(posedge pclk);
    cpu_stop <= 1'b1;
    @(posedge pclk);
    cpu_stop <= 1'b0;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic t_reset();
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_00C0);
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_00C0);
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    rdchk(nvm_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task automatic t_done_irq();
    wr(nvm_pkg::IRQ_EN_OFS, 32'h0000_0001);
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0020);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0080);
    rdchk(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0020);
    wait_irq(nvm_pkg::IRQ_FDONE_BIT);
    check(32'(irq), 32'h0000_0001);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_00C0);
    wr(nvm_pkg::IRQ_EN_OFS, 32'h0000_0000);
    wr(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    wr(nvm_pkg::IRQ_EN_OFS, 32'h0000_0001);
    rdchk(nvm_pkg::IRQ_EN_OFS, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(nvm_pkg::IRQ_CLR_OFS, 32'h0000_0001);
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
  endtask

  task automatic t_cancel();
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0020);
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0005);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0000);
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0005);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0000);
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0041);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0080);
    wait_irq(nvm_pkg::IRQ_FDONE_BIT);
    wr(nvm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
    idle();
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_00C0);
  endtask

  // Queued command runs after the first; STOP only once all is done
  task automatic t_queue_stop();
    wr(nvm_pkg::EE_CMD_OFS, 32'h0000_0020);
    wr(nvm_pkg::EE_CMD_OFS, 32'h0000_0040);
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_0000);
    wait_irq(nvm_pkg::IRQ_EDONE_BIT);
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_0080);
    wr(nvm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
    wait_irq(nvm_pkg::IRQ_EDONE_BIT);
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_00C0);
    stop_pulse();
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_00C0);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_00C0);
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0002);
    wr(nvm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
  endtask

  task automatic t_illegal();
    logic [2:0] mode [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic       ffail [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic       efail [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(nvm_pkg::CTRL_OFS, 32'(mode[i]));
      wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0077);
      wr(nvm_pkg::EE_CMD_OFS, 32'h0000_0077);
      rdchk(nvm_pkg::FLASH_STAT_OFS, 32'hC0 | 32'(ffail[i]) << 4);
      rdchk(nvm_pkg::EE_STAT_OFS, 32'hC0 | 32'(efail[i]) << 4);
      wr(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0010);
      wr(nvm_pkg::EE_STAT_OFS, 32'h0000_0010);
      rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_00C0);
      rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_00C0);
    end
    wr(nvm_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    check(32'(err), 32'h0000_0001);
  endtask

  task automatic t_aborts();
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0020);
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0040);
    stop_pulse();
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0001);
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_00C0);
    wr(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0041);
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_0001);
    rdchk(nvm_pkg::FLASH_CMD_OFS, 32'h0000_0040);
    idle();
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0004);
    wr(nvm_pkg::EE_CMD_OFS, 32'h0000_0020);
    stop_pulse();
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_0081);
    wr(nvm_pkg::EE_CMD_OFS, 32'h0000_0040);
    idle();
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_0081);
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_000C);
    do_reset();
    rdchk(nvm_pkg::FLASH_STAT_OFS, 32'h0000_00C0);
    rdchk(nvm_pkg::EE_STAT_OFS, 32'h0000_00C0);
    rdchk(nvm_pkg::IRQ_STAT_OFS, 32'h0000_0000);
  endtask

  initial begin
    do_reset();
    t_reset();
    t_done_irq();
    t_cancel();
    t_queue_stop();
    t_illegal();
    t_unmapped();
    t_aborts();
    report_and_stop();
  end
endmodule
